// *** sos_defs.svh ***
// constants of the system oscillator select block
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH

// register offsets
`define SOS_OFS_CTRL        4'h0
`define SOS_OFS_TRIM        4'h1

// control and trim register field positions
`define SOS_CTRL_FREQ_HI    6
`define SOS_CTRL_FREQ_LO    4
`define SOS_CTRL_FAST_STB   2
`define SOS_CTRL_SLOW_STB   1
`define SOS_CTRL_SRC_SEL    0
`define SOS_TRIM_HI         4

// reset values and the slow frequency select code
`define SOS_RST_FREQ_SEL    3'h6
`define SOS_RST_SRC_SEL     1'h0
`define SOS_RST_TRIM        5'h00
`define SOS_FREQ_SLOW       3'h0

// amplifier gain codes
`define SOS_GAIN_OFF        2'h0
`define SOS_GAIN_LOW        2'h1
`define SOS_GAIN_MED        2'h2
`define SOS_GAIN_HIGH       2'h3

// timing
`define SOS_CLK_HZ          64'd25000000
`define SOS_CLK_PERIOD_NS   40
`define SOS_FAST_OSC_HZ     64'd8000000
`define SOS_SLOW_OSC_HZ     64'd31000
`define SOS_TRIM_STEP_NS    1000
`define SOS_TRIM_STEP_CYC   ((`SOS_TRIM_STEP_NS + `SOS_CLK_PERIOD_NS - 1) / `SOS_CLK_PERIOD_NS)
`define SOS_TRIM_INC_UNIT   16'h0054

`endif

// *** sos_osc_select_assertions.sv ***
// port-level assertions of the oscillator select block
`timescale 1ns/10ps
module sos_osc_select_assertions
  import sos_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // configuration and timer enables
  input wire logic [2:0] oscillator_config_select_i,
  input wire logic       two_speed_startup_enable_i,
  input wire logic       power_up_timer_en_i,
  input wire logic       watchdog_timer_en_i,
  input wire logic       fail_safe_clock_monitor_en_i,
  // pins and status
  input wire logic       second_oscillator_pin_o,
  input wire logic       second_oscillator_pin_oe_o,
  input wire logic       first_pin_gpio_o,
  input wire logic       second_pin_gpio_o,
  input wire logic [1:0] amp_gain_o,
  input wire logic       fast_osc_en_o,
  input wire logic       slow_osc_en_o,
  input wire logic       internal_src_o
);
  logic [2:0] freq_ff;
  logic       src_ff;
  logic [4:0] trim_ff;
  logic       int_cfg;
  logic       run_en;
  logic       timers;

  // shadow of the writable fields, unmapped writes dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freq_ff <= 3'h6;
      src_ff  <= 1'h0;
      trim_ff <= 5'h00;
    end else if (reg_wr_i && reg_addr_i == 4'h0) begin
      freq_ff <= reg_wdata_i[6:4];
      src_ff  <= reg_wdata_i[0];
    end else if (reg_wr_i && reg_addr_i == 4'h1) begin
      trim_ff <= reg_wdata_i[4:0];
    end
  end

  // internal config modes and enable terms
  assign int_cfg = oscillator_config_select_i[2:1] == 2'h2;
  assign run_en  = src_ff || int_cfg || two_speed_startup_enable_i;
  assign timers  = power_up_timer_en_i || watchdog_timer_en_i || fail_safe_clock_monitor_en_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_gain_setting: assert property (1'b1 |=> amp_gain_o == ($past(oscillator_config_select_i[2]) ? 2'h0 :
    2'h1 + $past(oscillator_config_select_i[1:0]))) else $error("amplifier gain does not follow mode");
  a_divided_clock_output_pin_enable: assert property (1'b1 |=> second_oscillator_pin_oe_o ==
    $past(oscillator_config_select_i[2] && oscillator_config_select_i[0])) else $error("clock output enable wrong");
  a_gpio_pin_low: assert property (!second_oscillator_pin_oe_o |-> !second_oscillator_pin_o)
    else $error("released pin not held low");
  a_pin_release: assert property (1'b1 |=> first_pin_gpio_o == $past(int_cfg) && second_pin_gpio_o ==
    $past(oscillator_config_select_i inside {3'h3, 3'h4, 3'h6})) else $error("pin release wrong");
  a_source_choice: assert property (1'b1 |=> internal_src_o == $past(src_ff || int_cfg))
    else $error("system clock source wrong");
  a_fast_enable: assert property (1'b1 |=> fast_osc_en_o == $past(freq_ff != 3'h0 && run_en))
    else $error("fast oscillator enable wrong");
  a_slow_enable: assert property (1'b1 |=> slow_osc_en_o == $past((freq_ff == 3'h0 && run_en) || timers))
    else $error("slow oscillator enable wrong");
  a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data outside window");
  a_ctrl_read: assert property (reg_rd_i && reg_addr_i == 4'h0 |=>
    {reg_rdata_o[7:3], reg_rdata_o[0]} == {1'b0, freq_ff, 1'b0, src_ff}) else $error("control readback wrong");
  a_trim_read: assert property (reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o == {3'h0, trim_ff})
    else $error("trim readback wrong");

  c_ctrl_read: cover property (reg_rd_i && reg_addr_i == 4'h0);
  c_divided_clock_output_pin_run: cover property (second_oscillator_pin_oe_o && $rose(second_oscillator_pin_o));
  c_slow_only: cover property (slow_osc_en_o && !fast_osc_en_o);
endmodule

// *** sos_pkg.sv ***
// types of the system oscillator select block
package sos_pkg;

  // clock source modes held in the first configuration word
  typedef enum logic [2:0] {
    SOS_LOW_GAIN_CRYSTAL_MODE    = 3'h0,
    SOS_MEDIUM_GAIN_CRYSTAL_MODE = 3'h1,
    SOS_HIGH_GAIN_CRYSTAL_MODE   = 3'h2,
    SOS_EXTERNAL_CLOCK_MODE      = 3'h3,
    SOS_INTERNAL_OSC_GPIO_MODE   = 3'h4,
    SOS_INTERNAL_OSC_DIVIDED_CLOCK_OUTPUT_PIN_MODE = 3'h5,
    SOS_RES_CAP_GPIO_MODE        = 3'h6,
    SOS_RES_CAP_DIVIDED_CLOCK_OUTPUT_PIN_MODE      = 3'h7
  } sos_osc_mode_t;

  // trim slew states
  typedef enum logic [0:0] {
    SOS_TRIM_SETTLED = 1'b0,
    SOS_TRIM_MOVING  = 1'b1
  } sos_trim_state_t;

endpackage

// *** sos_rc_network.sv ***
// behavioural external rc network on the first oscillator pin
`timescale 1ns/10ps
module sos_rc_network (
  // control
  input  wire logic en_i,
  input  wire logic slow_i,
  // pin
  output logic      pin_o
);
  // charge and discharge, pin rests low while stopped
  initial begin
    pin_o = 1'b0;
    forever begin
      #(slow_i ? 430 : 110);
      pin_o = en_i ? ~pin_o : 1'b0;
    end
  end
endmodule

// *** sos_system_oscillator_select.sv ***
// system clock source selection, internal oscillator models and clock pin control
// Notes on behaviour
// - crystal modes drive amplifier gain low, medium or high respectively
// - resistor-capacitor divided_clock_output_pin mode drives second pin with source divided by four
// - resistor-capacitor gpio mode uses first pin, frees second pin as gpio
// - internal divided_clock_output_pin mode frees input pin, outputs internal clock divided by four
// - internal gpio mode frees both clock pins as gpio
// - internal config modes use the internal oscillators as system clock
// - fast internal oscillator nominally 8 MHz, adjustable by the trim value
// - slow internal oscillator nominally 31 kHz, untrimmed, independent of fast one
// - fast oscillator goes through postscaler; frequency select picks one of seven
// - fast oscillator enabled when select nonzero and source select, an internal config mode or two-speed set
// - read-only control bit reports fast oscillator stable
// - trim is 5-bit two's complement, reset to zero
// - fast frequency slews toward new trim during execution, no completion flag
// - trim never alters slow oscillator or timers running from it
// - software source select bit chooses external or internal clock
// - any reset loads frequency select with 110, the 4 MHz choice
// - select 000 picks slow oscillator; timers or monitor also enable it
// - source select 0 takes the clock from the configuration mode field
// - trim zero calibrated, positive raises, negative lowers frequency
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "sos_defs.svh"

module sos_system_oscillator_select
  import sos_pkg::*;
#(
  parameter int PHASE_W = 16
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // configuration word one and timer enables
  input  wire logic [2:0] oscillator_config_select_i,
  input  wire logic       two_speed_startup_enable_i,
  input  wire logic       power_up_timer_en_i,
  input  wire logic       watchdog_timer_en_i,
  input  wire logic       fail_safe_clock_monitor_en_i,
  // analog oscillator ready indications
  input  wire logic       fast_osc_ready_i,
  input  wire logic       slow_osc_ready_i,
  // clock pins
  input  wire logic       first_oscillator_pin_i,
  output logic            second_oscillator_pin_o,
  output logic            second_oscillator_pin_oe_o,
  output logic            first_pin_gpio_o,
  output logic            second_pin_gpio_o,
  output logic      [1:0] amp_gain_o,
  // clock source status and ticks
  output logic            fast_osc_en_o,
  output logic            slow_osc_en_o,
  output logic            internal_src_o,
  output logic            sys_clk_tick_o,
  output logic            fast_osc_tick_o,
  output logic            slow_osc_tick_o
);

  // elaboration check on the phase accumulator width
  if (PHASE_W < 12 || PHASE_W > 24) begin : g_bad_width
    $error("PHASE_W must lie between 12 and 24");
  end

  // phase increments derived from clock rates
  localparam logic [PHASE_W-1:0] FAST_INC =
    PHASE_W'((`SOS_FAST_OSC_HZ << PHASE_W) / `SOS_CLK_HZ);
  localparam logic [PHASE_W-1:0] SLOW_INC =
    PHASE_W'((`SOS_SLOW_OSC_HZ << PHASE_W) / `SOS_CLK_HZ);
  localparam logic [PHASE_W-1:0] TRIM_UNIT = PHASE_W'(`SOS_TRIM_INC_UNIT);
  localparam logic [4:0]         SLEW_LAST = 5'(`SOS_TRIM_STEP_CYC - 1);

  // whole state of the block
  typedef struct packed {
    logic [2:0]          freq_sel;
    logic                src_sel;
    logic [4:0]          trim;
    logic [4:0]          eff_trim;
    logic [4:0]          slew_cnt;
    sos_trim_state_t     slew_st;
    logic                fast_rdy_s1;
    logic                fast_rdy_s2;
    logic                slow_rdy_s1;
    logic                slow_rdy_s2;
    logic                pin_s1;
    logic                pin_s2;
    logic                pin_prev;
    logic [PHASE_W-1:0]  fast_acc;
    logic [PHASE_W-1:0]  slow_acc;
    logic [5:0]          post_cnt;
    logic [1:0]          div_cnt;
    logic [7:0]          rdata;
    logic                pin2_out;
    logic                pin2_oe;
    logic                pin1_gpio;
    logic                pin2_gpio;
    logic [1:0]          gain;
    logic                fast_en;
    logic                slow_en;
    logic                internal;
    logic                sys_tick;
    logic                fast_tick;
    logic                slow_tick;
  } sos_state_t;

  sos_state_t st_ff;
  sos_state_t nxt_st;

  // next-state logic
  always_comb begin
    sos_osc_mode_t      mode;
    logic               use_internal;
    logic               cfg_internal;
    logic               fast_en;
    logic               slow_en;
    logic [PHASE_W:0]   fast_sum;
    logic [PHASE_W:0]   slow_sum;
    logic [PHASE_W-1:0] trim_adj;
    logic [PHASE_W-1:0] fast_inc;
    logic [5:0]         post_mask;
    logic               post_tick;
    logic               ext_tick;
    logic               src_tick;
    logic               divided_clock_output_pin_mode;
    logic [7:0]         ctrl_rd;
    mode         = sos_osc_mode_t'(oscillator_config_select_i);
    use_internal = 1'b0;
    cfg_internal = 1'b0;
    fast_en      = 1'b0;
    slow_en      = 1'b0;
    fast_sum     = '0;
    slow_sum     = '0;
    trim_adj     = '0;
    fast_inc     = '0;
    post_mask    = 6'h00;
    post_tick    = 1'b0;
    ext_tick     = 1'b0;
    src_tick     = 1'b0;
    divided_clock_output_pin_mode  = 1'b0;
    ctrl_rd      = 8'h00;
    nxt_st       = st_ff;

    // synchronisers for pin and analog ready levels
    nxt_st.fast_rdy_s1 = fast_osc_ready_i;
    nxt_st.fast_rdy_s2 = st_ff.fast_rdy_s1;
    nxt_st.slow_rdy_s1 = slow_osc_ready_i;
    nxt_st.slow_rdy_s2 = st_ff.slow_rdy_s1;
    nxt_st.pin_s1      = first_oscillator_pin_i;
    nxt_st.pin_s2      = st_ff.pin_s1;
    nxt_st.pin_prev    = st_ff.pin_s2;

    // register writes
    if (reg_wr_i && reg_addr_i == `SOS_OFS_CTRL) begin
      nxt_st.freq_sel = reg_wdata_i[`SOS_CTRL_FREQ_HI:`SOS_CTRL_FREQ_LO];
      nxt_st.src_sel  = reg_wdata_i[`SOS_CTRL_SRC_SEL];
    end
    if (reg_wr_i && reg_addr_i == `SOS_OFS_TRIM) begin
      nxt_st.trim = reg_wdata_i[`SOS_TRIM_HI:0];
    end

    // register reads, data valid only in the following cycle
    ctrl_rd[`SOS_CTRL_FREQ_HI:`SOS_CTRL_FREQ_LO] = st_ff.freq_sel;
    ctrl_rd[`SOS_CTRL_FAST_STB] = st_ff.fast_rdy_s2 & st_ff.fast_en;
    ctrl_rd[`SOS_CTRL_SLOW_STB] = st_ff.slow_rdy_s2 & st_ff.slow_en;
    ctrl_rd[`SOS_CTRL_SRC_SEL]  = st_ff.src_sel;
    nxt_st.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SOS_OFS_CTRL: nxt_st.rdata = ctrl_rd;
        `SOS_OFS_TRIM: nxt_st.rdata = {3'h0, st_ff.trim};
        default:       nxt_st.rdata = 8'h00;
      endcase
    end

    // source choice: software bit, else configuration mode
    cfg_internal = (mode == SOS_INTERNAL_OSC_GPIO_MODE) ||
                   (mode == SOS_INTERNAL_OSC_DIVIDED_CLOCK_OUTPUT_PIN_MODE);
    use_internal = st_ff.src_sel | cfg_internal;

    // oscillator enables
    fast_en = (st_ff.freq_sel != `SOS_FREQ_SLOW) &&
              (use_internal || two_speed_startup_enable_i);
    slow_en = ((st_ff.freq_sel == `SOS_FREQ_SLOW) &&
               (use_internal || two_speed_startup_enable_i)) ||
              power_up_timer_en_i || watchdog_timer_en_i ||
              fail_safe_clock_monitor_en_i;
    nxt_st.fast_en  = fast_en;
    nxt_st.slow_en  = slow_en;
    nxt_st.internal = use_internal;

    // trim slews one step per interval toward the written value
    case (st_ff.slew_st)
      SOS_TRIM_SETTLED: begin
        nxt_st.slew_cnt = 5'h00;
        if (st_ff.eff_trim != st_ff.trim) begin
          nxt_st.slew_st = SOS_TRIM_MOVING;
        end
      end
      SOS_TRIM_MOVING: begin
        if (st_ff.slew_cnt == SLEW_LAST) begin
          nxt_st.slew_cnt = 5'h00;
          if ($signed(st_ff.eff_trim) < $signed(st_ff.trim)) begin
            nxt_st.eff_trim = st_ff.eff_trim + 5'h01;
          end else if ($signed(st_ff.eff_trim) > $signed(st_ff.trim)) begin
            nxt_st.eff_trim = st_ff.eff_trim - 5'h01;
          end else begin
            nxt_st.slew_st = SOS_TRIM_SETTLED;
          end
        end else begin
          nxt_st.slew_cnt = st_ff.slew_cnt + 5'h01;
        end
      end
      default: begin
        nxt_st.slew_st  = SOS_TRIM_SETTLED;
        nxt_st.slew_cnt = 5'h00;
      end
    endcase

    // fast oscillator: signed trim shifts the phase increment
    trim_adj = {{(PHASE_W-5){st_ff.eff_trim[4]}}, st_ff.eff_trim} * TRIM_UNIT;
    fast_inc = FAST_INC + trim_adj;
    if (fast_en) begin
      fast_sum = {1'b0, st_ff.fast_acc} + {1'b0, fast_inc};
      nxt_st.fast_acc = fast_sum[PHASE_W-1:0];
    end else begin
      nxt_st.fast_acc = '0;
    end
    nxt_st.fast_tick = fast_en & fast_sum[PHASE_W];

    // slow oscillator: fixed increment, no trim path at all
    if (slow_en) begin
      slow_sum = {1'b0, st_ff.slow_acc} + {1'b0, SLOW_INC};
      nxt_st.slow_acc = slow_sum[PHASE_W-1:0];
    end else begin
      nxt_st.slow_acc = '0;
    end
    nxt_st.slow_tick = slow_en & slow_sum[PHASE_W];

    // postscaler picks one of seven fast-derived rates
    case (st_ff.freq_sel)
      3'h7:    post_mask = 6'h00;
      3'h6:    post_mask = 6'h01;
      3'h5:    post_mask = 6'h03;
      3'h4:    post_mask = 6'h07;
      3'h3:    post_mask = 6'h0F;
      3'h2:    post_mask = 6'h1F;
      3'h1:    post_mask = 6'h3F;
      default: post_mask = 6'h00;
    endcase
    if (st_ff.fast_tick) begin
      nxt_st.post_cnt = st_ff.post_cnt + 6'h01;
    end
    post_tick = st_ff.fast_tick && ((st_ff.post_cnt & post_mask) == post_mask);

    // external source: rising edge on the first pin
    ext_tick = st_ff.pin_s2 & ~st_ff.pin_prev;

    // selected oscillator tick
    if (use_internal) begin
      if (st_ff.freq_sel == `SOS_FREQ_SLOW) begin
        src_tick = st_ff.slow_tick;
      end else begin
        src_tick = post_tick;
      end
    end else begin
      src_tick = ext_tick;
    end
    nxt_st.sys_tick = src_tick;

    // free-running divide-by-four counter
    if (src_tick) begin
      nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
    end

    // pin functions and amplifier gain per mode
    nxt_st.gain      = `SOS_GAIN_OFF;
    nxt_st.pin1_gpio = 1'b0;
    nxt_st.pin2_gpio = 1'b0;
    divided_clock_output_pin_mode      = 1'b0;
    case (mode)
      SOS_LOW_GAIN_CRYSTAL_MODE:    nxt_st.gain = `SOS_GAIN_LOW;
      SOS_MEDIUM_GAIN_CRYSTAL_MODE: nxt_st.gain = `SOS_GAIN_MED;
      SOS_HIGH_GAIN_CRYSTAL_MODE:   nxt_st.gain = `SOS_GAIN_HIGH;
      SOS_EXTERNAL_CLOCK_MODE:      nxt_st.pin2_gpio = 1'b1;
      SOS_RES_CAP_DIVIDED_CLOCK_OUTPUT_PIN_MODE:      divided_clock_output_pin_mode = 1'b1;
      SOS_RES_CAP_GPIO_MODE:        nxt_st.pin2_gpio = 1'b1;
      SOS_INTERNAL_OSC_DIVIDED_CLOCK_OUTPUT_PIN_MODE: begin
        nxt_st.pin1_gpio = 1'b1;
        divided_clock_output_pin_mode      = 1'b1;
      end
      SOS_INTERNAL_OSC_GPIO_MODE: begin
        nxt_st.pin1_gpio = 1'b1;
        nxt_st.pin2_gpio = 1'b1;
      end
      default: nxt_st.gain = `SOS_GAIN_OFF;
    endcase

    // divided clock drives the second pin only in divided_clock_output_pin modes
    nxt_st.pin2_oe  = divided_clock_output_pin_mode;
    if (divided_clock_output_pin_mode) begin
      nxt_st.pin2_out = nxt_st.div_cnt[1];
    end else begin
      nxt_st.pin2_out = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff          <= '0;
      st_ff.freq_sel <= `SOS_RST_FREQ_SEL;
      st_ff.src_sel  <= `SOS_RST_SRC_SEL;
      st_ff.trim     <= `SOS_RST_TRIM;
      st_ff.eff_trim <= `SOS_RST_TRIM;
      st_ff.slew_st  <= SOS_TRIM_SETTLED;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o                = st_ff.rdata;
  assign second_oscillator_pin_o    = st_ff.pin2_out;
  assign second_oscillator_pin_oe_o = st_ff.pin2_oe;
  assign first_pin_gpio_o           = st_ff.pin1_gpio;
  assign second_pin_gpio_o          = st_ff.pin2_gpio;
  assign amp_gain_o                 = st_ff.gain;
  assign fast_osc_en_o              = st_ff.fast_en;
  assign slow_osc_en_o              = st_ff.slow_en;
  assign internal_src_o             = st_ff.internal;
  assign sys_clk_tick_o             = st_ff.sys_tick;
  assign fast_osc_tick_o            = st_ff.fast_tick;
  assign slow_osc_tick_o            = st_ff.slow_tick;

endmodule

// *** test_system_oscillator_select.sv ***
// self-checking bench of the oscillator select block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module test_system_oscillator_select;
  import sos_pkg::*;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd_s = 1'b0;
  logic [2:0] cfg = 3'h0;
  logic       two_sp = 1'b0;
  logic       put_en = 1'b0;
  logic       wdog_en = 1'b0;
  logic       fmon_en = 1'b0;
  logic       frdy = 1'b0;
  logic       srdy = 1'b1;
  logic       rc_en = 1'b0;
  logic       rc_slow = 1'b0;
  wire        pin1, pin2, oe, g1, g2, fen, sen, isrc, sys_t, fast_t, slow_t;
  wire  [1:0] gain;
  wire  [7:0] rdata;
  int         error_cnt = 0;
  int         num_checks = 0;
  // rows: mode, gain, oe, first gpio, second gpio, internal source
  logic [8:0] rows [8] = '{9'h010, 9'h060, 9'h0B0, 9'h0C2, 9'h107, 9'h14D, 9'h182, 9'h1C8};
  logic [4:0] tv [3] = '{5'h00, 5'h0F, 5'h10};

  always #20 clk_i = ~clk_i;

  sos_rc_network rc (.en_i(rc_en), .slow_i(rc_slow), .pin_o(pin1));
  sos_system_oscillator_select uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .oscillator_config_select_i(cfg),
    .two_speed_startup_enable_i(two_sp), .power_up_timer_en_i(put_en), .watchdog_timer_en_i(wdog_en),
    .fail_safe_clock_monitor_en_i(fmon_en), .fast_osc_ready_i(frdy), .slow_osc_ready_i(srdy),
    .first_oscillator_pin_i(pin1), .second_oscillator_pin_o(pin2), .second_oscillator_pin_oe_o(oe),
    .first_pin_gpio_o(g1), .second_pin_gpio_o(g2), .amp_gain_o(gain), .fast_osc_en_o(fen),
    .slow_osc_en_o(sen), .internal_src_o(isrc), .sys_clk_tick_o(sys_t), .fast_osc_tick_o(fast_t),
    .slow_osc_tick_o(slow_t));

  // register bus cycles
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // counted pulses between two marker events, pin rises or system ticks
  task automatic gap(input logic use_pin, output int n);
    int k;
    logic p;
    k = 0;
    n = 0;
    p = pin2;
    repeat (1000) if (k < 2) begin
      @(posedge clk_i);
      #1;
      if (k == 1) n += use_pin ? (sys_t === 1'b1) : (fast_t === 1'b1);
      if (use_pin ? (pin2 === 1'b1 && p === 1'b0) : (sys_t === 1'b1)) k++;
      p = pin2;
    end
  endtask
  task automatic do_reset;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask
  task automatic check_reset;
    logic [7:0] d;
    rd_reg(4'h0, d);
    `CHK(d & 8'hF9, 8'h60)
    rd_reg(4'h1, d);
    `CHK(d, 8'h00)
    $display("test reset values done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0] d;
    int n;
    int fc [3];
    int sc [3];
    do_reset;
    check_reset;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      cfg <= rows[i][8:6];
      cyc(3);
      `CHK(gain, rows[i][5:4])
      `CHK({oe, g1, g2, isrc}, rows[i][3:0])
    end
    $display("test config rows done");
    wr_reg(4'h0, 8'hF7);
    rd_reg(4'h0, d);
    `CHK(d & 8'hF9, 8'h71)
    wr_reg(4'h1, 8'hFF);
    rd_reg(4'h1, d);
    `CHK(d, 8'h1F)
    wr_reg(4'h5, 8'hAA);
    rd_reg(4'h5, d);
    `CHK(d, 8'h00)
    @(posedge clk_i);
    frdy <= 1'b1;
    cyc(4);
    rd_reg(4'h0, d);
    `CHK(d[2], 1'b1)
    @(posedge clk_i);
    frdy <= 1'b0;
    cyc(4);
    rd_reg(4'h0, d);
    `CHK(d[2], 1'b0)
    $display("test registers done");
    wr_reg(4'h0, 8'h60);
    cfg <= 3'h0;
    cyc(3);
    `CHK(fen, 1'b0)
    @(posedge clk_i);
    two_sp <= 1'b1;
    cyc(3);
    `CHK(fen, 1'b1)
    wr_reg(4'h0, 8'h00);
    cyc(3);
    `CHK({fen, sen}, 2'h1)
    @(posedge clk_i);
    two_sp <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {put_en, wdog_en, fmon_en} <= 3'h4 >> i;
      cyc(3);
      `CHK(sen, 1'b1)
    end
    @(posedge clk_i);
    {put_en, wdog_en, fmon_en} <= 3'h0;
    $display("test enables done");
    for (int k = 1; k < 8; k++) begin
      wr_reg(4'h0, {1'b0, 3'(k), 4'h1});
      cyc(2);
      gap(1'b0, n);
      `CHK(n, 1 << (7 - k))
    end
    $display("test postscaler done");
    @(posedge clk_i);
    rc_en <= 1'b1;
    cfg <= 3'h7;
    wr_reg(4'h0, 8'h60);
    for (int y = 0; y < 2; y++) begin
      rc_slow <= y[0];
      cyc(60);
      gap(1'b1, n);
      `CHK(n, 4)
    end
    @(posedge clk_i);
    rc_en <= 1'b0;
    cfg <= 3'h5;
    wr_reg(4'h0, 8'h70);
    gap(1'b1, n);
    `CHK(n, 4)
    $display("test divided clock done");
    @(posedge clk_i);
    cfg <= 3'h4;
    put_en <= 1'b1;
    wr_reg(4'h0, 8'h71);
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h1, {3'h0, tv[i]});
      cyc(900);
      fc[i] = 0;
      sc[i] = 0;
      repeat (4000) begin
        cyc(1);
        fc[i] += (fast_t === 1'b1);
        sc[i] += (slow_t === 1'b1);
      end
    end
    `CHK(fc[1] > fc[0], 1'b1)
    `CHK(fc[2] < fc[0], 1'b1)
    `CHK(sc[0] >= 4 && sc[1] - sc[0] <= 1 && sc[0] - sc[1] <= 1, 1'b1)
    `CHK(sc[0] - sc[2] <= 1 && sc[2] - sc[0] <= 1, 1'b1)
    $display("test trim done");
    @(posedge clk_i);
    do_reset;
    check_reset;
    report_and_stop;
  end

  // watchdog well past the expected run
  initial begin
    #(40 * 60000);
    error_cnt++;
    report_and_stop;
  end
endmodule

bind sos_system_oscillator_select sos_osc_select_assertions chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .oscillator_config_select_i(oscillator_config_select_i),
  .two_speed_startup_enable_i(two_speed_startup_enable_i), .power_up_timer_en_i(power_up_timer_en_i),
  .watchdog_timer_en_i(watchdog_timer_en_i), .fail_safe_clock_monitor_en_i(fail_safe_clock_monitor_en_i),
  .second_oscillator_pin_o(second_oscillator_pin_o), .second_oscillator_pin_oe_o(second_oscillator_pin_oe_o),
  .first_pin_gpio_o(first_pin_gpio_o), .second_pin_gpio_o(second_pin_gpio_o), .amp_gain_o(amp_gain_o),
  .fast_osc_en_o(fast_osc_en_o), .slow_osc_en_o(slow_osc_en_o), .internal_src_o(internal_src_o));
